/* logic/smpr_pkg.sv */
// Package: motion parameter register map, reset values, field layout and shared types
`default_nettype none
package smpr_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SMPR_CLK_PERIOD_NS = 100; // 10 MHz system clock
  localparam int SMPR_TICK_NS = 250; // Profile tick period

  // ----------------------------------------------------------------
  // Register addresses on the command port
  // ----------------------------------------------------------------
  localparam logic [4:0] SMPR_ADDR_ELPOS = 5'h02;
  localparam logic [4:0] SMPR_ADDR_MARK = 5'h03;
  localparam logic [4:0] SMPR_ADDR_SPEED = 5'h04;
  localparam logic [4:0] SMPR_ADDR_UP_RATE = 5'h05;
  localparam logic [4:0] SMPR_ADDR_DN_RATE = 5'h06;
  localparam logic [4:0] SMPR_ADDR_MAXSPD = 5'h07;
  localparam logic [4:0] SMPR_ADDR_MINSPD = 5'h08;
  localparam logic [4:0] SMPR_ADDR_HOLD = 5'h09;
  localparam logic [4:0] SMPR_ADDR_RUN = 5'h0a;
  localparam logic [4:0] SMPR_ADDR_UP = 5'h0b;
  localparam logic [4:0] SMPR_ADDR_DOWN = 5'h0c;
  localparam logic [4:0] SMPR_ADDR_KNEE = 5'h0d;
  localparam logic [4:0] SMPR_ADDR_FSSPD = 5'h15;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [8:0] SMPR_RST_ELPOS = 9'h000;
  localparam logic [21:0] SMPR_RST_MARK = 22'h00_0000;
  localparam logic [11:0] SMPR_RST_UP_RATE = 12'h08a;
  localparam logic [11:0] SMPR_RST_DN_RATE = 12'h08a;
  localparam logic [9:0] SMPR_RST_MAXSPD = 10'h041;
  localparam logic [12:0] SMPR_RST_MINSPD = 13'h0000;
  localparam logic [10:0] SMPR_RST_FSSPD = 11'h027;
  localparam logic [7:0] SMPR_RST_AMP = 8'h29;
  localparam logic [13:0] SMPR_RST_KNEE = 14'h0408;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SMPR_OPT_EN_BIT = 12; // Low-speed optimize enable
  localparam int SMPR_BOOST_BIT = 10; // Full-step square-wave boost
  localparam int SMPR_MICRO_BITS = 7; // Microstep part of phase
  localparam int SMPR_SPEED_W = 20; // Current speed, 0.28 format
  localparam int SMPR_DATA_W = 22; // Widest register

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SMPR_STOPPED = 2'b00,
    SMPR_ACCEL = 2'b01,
    SMPR_CONST = 2'b10,
    SMPR_DECEL = 2'b11
  } smpr_motion_e;

  // One register access from the serial command decoder
  typedef struct packed {
    logic wr;
    logic rd;
    logic [4:0] addr;
    logic [SMPR_DATA_W-1:0] data;
  } smpr_req_s;

  // Drive settings towards the PWM modulators
  typedef struct packed {
    logic [7:0] amplitude;
    logic full_step;
    logic boost;
  } smpr_drive_s;

endpackage
`default_nettype wire

/* logic/smpr_tick_gen.sv */
// Fractional divider making the 250 ns profile tick enable
`timescale 1ns/1ns
`default_nettype none
module smpr_tick_gen
  import smpr_pkg::*;
#(
  parameter int CLK_NS = SMPR_CLK_PERIOD_NS,
  parameter int TICK_NS = SMPR_TICK_NS
)
(
  input wire logic clk,
  input wire logic rst,
  output logic tick
);
  // ----------------------------------------------------------------
  // Phase accumulator
  // ----------------------------------------------------------------
  // Tick is not a whole number of clocks, so spacing alternates and
  // the average period stays exact
  logic [15:0] phase_ns; // Time since last tick, in ns
  logic [16:0] sum_ns; // Phase plus one clock period

  assign sum_ns = {1'b0, phase_ns} + 17'(CLK_NS);

  // Advance and emit one-cycle pulse
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phase_ns <= 16'h0000;
      tick <= 1'b0;
    end
    else if (sum_ns >= 17'(TICK_NS))
    begin
      phase_ns <= 16'(sum_ns - 17'(TICK_NS));
      tick <= 1'b1;
    end
    else
    begin
      phase_ns <= sum_ns[15:0];
      tick <= 1'b0;
    end
  end
endmodule // smpr_tick_gen
`default_nettype wire

/* logic/smpr_drive_select.sv */
// Amplitude selection and full-step switch towards the PWM modulators
`timescale 1ns/1ns
`default_nettype none
module smpr_drive_select
  import smpr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire smpr_motion_e motion,
  input wire logic [SMPR_SPEED_W-1:0] speed,
  input wire logic [10:0] full_step_threshold_config,
  input wire logic [7:0] hold_amplitude,
  input wire logic [7:0] run_amplitude,
  input wire logic [7:0] ramp_up_start_amplitude,
  input wire logic [7:0] ramp_down_start_amplitude,
  output smpr_drive_s drive
);
  // ----------------------------------------------------------------
  // Full-step threshold
  // ----------------------------------------------------------------
  // Field plus one half in 2^-18 units, moved to 2^-28 speed units
  logic [SMPR_SPEED_W-1:0] fs_thr;
  assign fs_thr = {full_step_threshold_config[9:0], 1'b1, 9'h000};

  // ----------------------------------------------------------------
  // Registered drive word
  // ----------------------------------------------------------------
  // Strict compare: field h3FF never engages full step, zero still needs motion
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      drive <= '0;
    end
    else
    begin
      drive.full_step <= (speed > fs_thr);
      drive.boost <= full_step_threshold_config[SMPR_BOOST_BIT];
      // Raw code; scaling by supply/256 happens in the modulator
      case (motion)
        SMPR_STOPPED: drive.amplitude <= hold_amplitude;
        SMPR_CONST: drive.amplitude <= run_amplitude;
        SMPR_ACCEL: drive.amplitude <= ramp_up_start_amplitude;
        SMPR_DECEL: drive.amplitude <= ramp_down_start_amplitude;
        default: drive.amplitude <= hold_amplitude;
      endcase
    end
  end
endmodule // smpr_drive_select
`default_nettype wire

/* logic/smpr_motion_regs.sv */
// Motion parameter registers, profile generator and electrical phase counter
`timescale 1ns/1ns
`default_nettype none
module smpr_motion_regs
  import smpr_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire smpr_pkg::smpr_req_s req,
  input wire logic move_req,
  input wire logic move_dir,
  input wire logic [2:0] step_resolution,
  input wire logic cmd_error_clr,
  output logic [SMPR_DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic cmd_error,
  output logic [8:0] electrical_phase_position,
  output logic step_pulse,
  output logic [1:0] motion_state,
  output logic low_velocity_optimize_enable,
  output logic [11:0] low_velocity_threshold,
  output logic [13:0] bemf_knee_speed,
  output smpr_pkg::smpr_drive_s drive
);
  import smpr_pkg::*;

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [21:0] saved_reference_position; // Signed, step-mode units
  logic [11:0] speed_up_rate; // 0.40 steps/tick^2
  logic [11:0] slow_down_rate; // 0.40 steps/tick^2
  logic [9:0] max_speed; // 0.18 steps/tick
  logic [12:0] low_velocity_config; // Optimize bit plus min speed
  logic [10:0] full_step_threshold_config; // Boost bit plus threshold
  logic [7:0] hold_amplitude;
  logic [7:0] run_amplitude;
  logic [7:0] ramp_up_start_amplitude;
  logic [7:0] ramp_down_start_amplitude;

  // ----------------------------------------------------------------
  // Profile state
  // ----------------------------------------------------------------
  smpr_motion_e motion; // Profile phase
  smpr_motion_e next_motion;
  logic [31:0] vel; // Speed with 40 fraction bits
  logic [31:0] next_vel;
  logic [27:0] pos_frac; // Sub-step position accumulator
  logic tick; // 250 ns enable
  logic moving; // Any state but stopped
  logic [SMPR_SPEED_W-1:0] speed; // Current speed, 0.28

  // ----------------------------------------------------------------
  // Write classification
  // ----------------------------------------------------------------
  logic wr_locked; // Register only writable while stopped
  logic wr_refused; // Write dropped
  logic wr_error; // Write raises the error flag
  logic wr_ok; // Write lands in storage

  assign moving = (motion != SMPR_STOPPED);
  assign speed = vel[31:12];

  // Stop-only registers drop the write when busy
  assign wr_locked = (req.addr == SMPR_ADDR_ELPOS) || (req.addr == SMPR_ADDR_UP_RATE)
                   || (req.addr == SMPR_ADDR_DN_RATE) || (req.addr == SMPR_ADDR_KNEE);
  assign wr_refused = req.wr && ((wr_locked && moving)
                   || (req.addr == SMPR_ADDR_SPEED));
  // Low-speed config still stores but is flagged
  assign wr_error = wr_refused
                 || (req.wr && moving && (req.addr == SMPR_ADDR_MINSPD));
  assign wr_ok = req.wr && !wr_refused;

  // ----------------------------------------------------------------
  // Tick divider
  // ----------------------------------------------------------------
  smpr_tick_gen #(
    .CLK_NS(SMPR_CLK_PERIOD_NS),
    .TICK_NS(SMPR_TICK_NS)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  // ----------------------------------------------------------------
  // Parameter register writes
  // ----------------------------------------------------------------
  // Narrow registers take the low bits of the write data
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      saved_reference_position <= SMPR_RST_MARK;
      speed_up_rate <= SMPR_RST_UP_RATE;
      slow_down_rate <= SMPR_RST_DN_RATE;
      max_speed <= SMPR_RST_MAXSPD;
      low_velocity_config <= SMPR_RST_MINSPD;
      full_step_threshold_config <= SMPR_RST_FSSPD;
      hold_amplitude <= SMPR_RST_AMP;
      run_amplitude <= SMPR_RST_AMP;
      ramp_up_start_amplitude <= SMPR_RST_AMP;
      ramp_down_start_amplitude <= SMPR_RST_AMP;
      bemf_knee_speed <= SMPR_RST_KNEE;
    end
    else if (wr_ok)
    begin
      case (req.addr)
        SMPR_ADDR_MARK: saved_reference_position <= req.data[21:0];
        SMPR_ADDR_UP_RATE: speed_up_rate <= req.data[11:0];
        SMPR_ADDR_DN_RATE: slow_down_rate <= req.data[11:0];
        SMPR_ADDR_MAXSPD: max_speed <= req.data[9:0];
        SMPR_ADDR_MINSPD: low_velocity_config <= req.data[12:0];
        SMPR_ADDR_FSSPD: full_step_threshold_config <= req.data[10:0];
        SMPR_ADDR_HOLD: hold_amplitude <= req.data[7:0];
        SMPR_ADDR_RUN: run_amplitude <= req.data[7:0];
        SMPR_ADDR_UP: ramp_up_start_amplitude <= req.data[7:0];
        SMPR_ADDR_DOWN: ramp_down_start_amplitude <= req.data[7:0];
        SMPR_ADDR_KNEE: bemf_knee_speed <= req.data[13:0];
        default: ; // Phase handled below, unmapped ignored
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Low-speed outputs
  // ----------------------------------------------------------------
  // Registered copies so outputs come from flops
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      low_velocity_optimize_enable <= 1'b0;
      low_velocity_threshold <= 12'h000;
    end
    else
    begin
      low_velocity_optimize_enable <= low_velocity_config[SMPR_OPT_EN_BIT];
      low_velocity_threshold <= low_velocity_config[11:0];
    end
  end

  // ----------------------------------------------------------------
  // Read-back
  // ----------------------------------------------------------------
  // Answer one clock after the read; unmapped reads return zero
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_data <= '0;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= req.rd;
      case (req.addr)
        SMPR_ADDR_ELPOS: rd_data <= 22'(electrical_phase_position);
        SMPR_ADDR_MARK: rd_data <= saved_reference_position;
        SMPR_ADDR_SPEED: rd_data <= 22'(speed);
        SMPR_ADDR_UP_RATE: rd_data <= 22'(speed_up_rate);
        SMPR_ADDR_DN_RATE: rd_data <= 22'(slow_down_rate);
        SMPR_ADDR_MAXSPD: rd_data <= 22'(max_speed);
        SMPR_ADDR_MINSPD: rd_data <= 22'(low_velocity_config);
        SMPR_ADDR_FSSPD: rd_data <= 22'(full_step_threshold_config);
        SMPR_ADDR_HOLD: rd_data <= 22'(hold_amplitude);
        SMPR_ADDR_RUN: rd_data <= 22'(run_amplitude);
        SMPR_ADDR_UP: rd_data <= 22'(ramp_up_start_amplitude);
        SMPR_ADDR_DOWN: rd_data <= 22'(ramp_down_start_amplitude);
        SMPR_ADDR_KNEE: rd_data <= 22'(bemf_knee_speed);
        default: rd_data <= '0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Command error flag
  // ----------------------------------------------------------------
  // Sticky; a new error in the clear cycle wins over the clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cmd_error <= 1'b0;
    end
    else if (wr_error)
    begin
      cmd_error <= 1'b1;
    end
    else if (cmd_error_clr)
    begin
      cmd_error <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Profile generator
  // ----------------------------------------------------------------
  logic [31:0] max_vel; // Max speed in 0.40
  logic [31:0] min_vel; // Effective min speed in 0.40
  logic [32:0] vel_up; // Speed plus acceleration
  logic [32:0] vel_dn; // Speed minus deceleration

  // Optimize enable forces the profile floor to zero
  assign max_vel = {max_speed, 22'h00_0000};
  assign min_vel = low_velocity_config[SMPR_OPT_EN_BIT] ? 32'h0000_0000
                 : {4'h0, low_velocity_config[11:0], 16'h0000};
  assign vel_up = {1'b0, vel} + 33'(speed_up_rate);
  assign vel_dn = {1'b0, vel} - 33'(slow_down_rate);

  // Next speed and phase of the profile
  always_comb
  begin
    next_motion = motion;
    next_vel = vel;
    case (motion)
      SMPR_STOPPED:
      begin
        if (move_req)
        begin
          next_motion = SMPR_ACCEL;
          next_vel = min_vel;
        end
      end
      SMPR_ACCEL:
      begin
        if (!move_req)
        begin
          next_motion = SMPR_DECEL;
        end
        else if (vel_up >= {1'b0, max_vel})
        begin
          next_motion = SMPR_CONST;
          next_vel = max_vel;
        end
        else
        begin
          next_vel = vel_up[31:0];
        end
      end
      SMPR_CONST:
      begin
        if (!move_req)
        begin
          next_motion = SMPR_DECEL;
        end
        else if (vel > max_vel)
        begin
          next_vel = max_vel;
        end
      end
      SMPR_DECEL:
      begin
        if (move_req)
        begin
          next_motion = SMPR_ACCEL;
        end
        else if (vel_dn[32] || (vel_dn[31:0] <= min_vel))
        begin
          next_motion = SMPR_STOPPED;
          next_vel = 32'h0000_0000;
        end
        else
        begin
          next_vel = vel_dn[31:0];
        end
      end
      default:
      begin
        next_motion = SMPR_STOPPED;
        next_vel = 32'h0000_0000;
      end
    endcase
  end

  // Profile advances only on the tick enable
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      motion <= SMPR_STOPPED;
      vel <= 32'h0000_0000;
    end
    else if (tick)
    begin
      motion <= next_motion;
      vel <= next_vel;
    end
  end

  // ----------------------------------------------------------------
  // Step generation and electrical phase
  // ----------------------------------------------------------------
  logic [28:0] pos_sum; // Accumulator plus speed
  logic [8:0] phase_inc; // Phase advance per step
  assign pos_sum = {1'b0, pos_frac} + 29'(speed);
  assign phase_inc = 9'h080 >> step_resolution;

  // Carry out of the fraction is one step at the chosen resolution;
  // host writes, taken only while stopped, make the sine generator jump at once
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pos_frac <= 28'h000_0000;
      step_pulse <= 1'b0;
      electrical_phase_position <= SMPR_RST_ELPOS;
    end
    else
    begin
      step_pulse <= 1'b0;
      if (wr_ok && (req.addr == SMPR_ADDR_ELPOS))
      begin
        // Misaligned values are the host's concern
        electrical_phase_position <= req.data[8:0];
      end
      else if (tick && moving)
      begin
        pos_frac <= pos_sum[27:0];
        if (pos_sum[28])
        begin
          step_pulse <= 1'b1;
          electrical_phase_position <= move_dir ? electrical_phase_position + phase_inc
                                     : electrical_phase_position - phase_inc;
        end
      end
    end
  end

  // Expose profile phase
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      motion_state <= SMPR_STOPPED;
    end
    else
    begin
      motion_state <= motion;
    end
  end

  // ----------------------------------------------------------------
  // Drive selection
  // ----------------------------------------------------------------
  smpr_drive_select u_drive (
    .clk(clk),
    .rst(rst),
    .motion(motion),
    .speed(speed),
    .full_step_threshold_config(full_step_threshold_config),
    .hold_amplitude(hold_amplitude),
    .run_amplitude(run_amplitude),
    .ramp_up_start_amplitude(ramp_up_start_amplitude),
    .ramp_down_start_amplitude(ramp_down_start_amplitude),
    .drive(drive)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_locked_write_dropped: assert property (
    (req.wr && moving && req.addr == SMPR_ADDR_UP_RATE) |=> $stable(speed_up_rate) && cmd_error)
    else $error("acceleration changed while moving");
  chk_speed_write_flag: assert property (
    (req.wr && req.addr == SMPR_ADDR_SPEED) |=> cmd_error && ($stable(vel) || $past(tick)))
    else $error("speed write not flagged");
  chk_minspd_busy_flag: assert property (
    (req.wr && moving && req.addr == SMPR_ADDR_MINSPD) |=> cmd_error)
    else $error("low-speed config busy write not flagged");
  chk_phase_applied: assert property (
    (req.wr && !moving && req.addr == SMPR_ADDR_ELPOS)
      |=> electrical_phase_position == $past(req.data[8:0]))
    else $error("phase write not applied next cycle");
  chk_speed_capped: assert property (
    (tick && motion == SMPR_CONST && move_req) |=> vel <= $past(max_vel))
    else $error("speed above maximum at constant speed");
  chk_stopped_zero: assert property (
    (motion == SMPR_STOPPED) |-> vel == 32'h0000_0000)
    else $error("speed nonzero while stopped");
  chk_accel_adds_rate: assert property (
    (tick && motion == SMPR_ACCEL && move_req && vel_up < {1'b0, max_vel})
      |=> vel == $past(vel) + 32'($past(speed_up_rate)))
    else $error("acceleration step wrong");
  chk_error_sticky: assert property (
    (cmd_error && !cmd_error_clr) |=> cmd_error)
    else $error("error flag dropped without clear");
  chk_hold_amp: assert property (
    (motion == SMPR_STOPPED && $stable(motion) && $stable(hold_amplitude))
      |=> drive.amplitude == $past(hold_amplitude))
    else $error("hold amplitude not applied");
  chk_full_step_thr: assert property (
    (speed > {full_step_threshold_config[9:0], 1'b1, 9'h000}) |=> drive.full_step)
    else $error("full step not engaged above threshold");
endmodule // smpr_motion_regs
`default_nettype wire

/* testbench/smpr_host.sv */
// Host model issuing register accesses on the command port
`timescale 1ns/1ns
`default_nettype none
module smpr_host
  import smpr_pkg::*;
(
  input wire logic clk,
  output smpr_pkg::smpr_req_s req
);
  initial req = '0;
  // One-cycle write pulse, changed off the sampling edge
  task automatic wr(input logic [4:0] a, input logic [21:0] d);
    @(negedge clk) req = '{1'b1, 1'b0, a, d};
    @(negedge clk) req = '0;
  endtask
  // One-cycle read pulse; data stands when this returns
  task automatic rd(input logic [4:0] a);
    @(negedge clk) req = '{1'b0, 1'b1, a, 22'h00_0000};
    @(negedge clk) req = '0;
  endtask
endmodule // smpr_host
`default_nettype wire

/* testbench/stepper_motion_parameter_regs_tb.sv */
// Self-checking bench for the motion parameter registers
`timescale 1ns/1ns
`default_nettype none
module stepper_motion_parameter_regs_tb;
  import smpr_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic move_req = 1'b0;
  logic err_clr = 1'b0;
  logic [21:0] rd_data;
  logic rd_valid, cmd_error, lv_opt;
  logic [8:0] phase;
  logic [1:0] mst;
  logic [11:0] lv_thr;
  logic [13:0] knee;
  logic step_pulse;
  smpr_req_s req;
  smpr_drive_s drv;
  logic [21:0] sh [32]; // Expected register contents
  logic [21:0] d;
  logic [4:0] a;
  int fails = 0;
  int check_count = 0;
  int steps = 0; // Steps seen, one edge late like the phase read-back
  int seed = 32'h3102;
  smpr_host host (.clk(clk), .req(req));
  smpr_motion_regs uut (.clk(clk), .rst(rst), .req(req), .move_req(move_req),
    .move_dir(1'b1), .step_resolution(3'h7), .cmd_error_clr(err_clr), .rd_data(rd_data),
    .rd_valid(rd_valid), .cmd_error(cmd_error), .electrical_phase_position(phase),
    .step_pulse(step_pulse), .motion_state(mst), .low_velocity_optimize_enable(lv_opt),
    .low_velocity_threshold(lv_thr), .bemf_knee_speed(knee), .drive(drv));
  always #50 clk = ~clk;
  // At 1/128 resolution counting up, each step moves the phase by one
  always @(posedge clk) if (step_pulse) steps <= steps + 1;
  task automatic check(input string n, input logic [21:0] s, input logic [21:0] e);
    check_count++;
    if (s !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // Writable width of each register
  function automatic logic [21:0] wm(input logic [4:0] x);
    case (x)
      SMPR_ADDR_ELPOS: return 22'h00_01ff;
      SMPR_ADDR_MARK: return 22'h3f_ffff;
      SMPR_ADDR_MAXSPD: return 22'h00_03ff;
      SMPR_ADDR_MINSPD: return 22'h00_1fff;
      SMPR_ADDR_FSSPD: return 22'h00_07ff;
      SMPR_ADDR_KNEE: return 22'h00_3fff;
      SMPR_ADDR_UP_RATE, SMPR_ADDR_DN_RATE: return 22'h00_0fff;
      default: return 22'h00_00ff;
    endcase
  endfunction
  task automatic rdchk(input logic [4:0] x);
    host.rd(x);
    check("rd_valid", {21'h0, rd_valid}, 22'h1);
    check("rd_data", rd_data, (x == SMPR_ADDR_ELPOS) ? 22'(9'(sh[x] + 22'(steps))) : sh[x]);
  endtask
  task automatic put(input logic [4:0] x, input logic [21:0] v);
    host.wr(x, v);
    sh[x] = v & wm(x);
  endtask
  task automatic err(input logic e);
    check("cmd_error", {21'h0, cmd_error}, {21'h0, e});
  endtask
  // Clear pulse, then the flag must read low
  task automatic clr;
    @(negedge clk) err_clr = 1'b1;
    @(negedge clk) err_clr = 1'b0;
    err(1'b0);
  endtask
  task automatic wst(input logic [1:0] s);
    for (int n = 0; n < 6000 && mst !== s; n++) @(negedge clk);
    @(negedge clk);
    check("motion_state", {20'h0, mst}, {20'h0, s});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog against a stuck profile
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    results();
  end
  initial
  begin
    sh = '{default: 22'h0};
    sh[SMPR_ADDR_UP_RATE] = 22'(SMPR_RST_UP_RATE);
    sh[SMPR_ADDR_DN_RATE] = 22'(SMPR_RST_DN_RATE);
    sh[SMPR_ADDR_MAXSPD] = 22'h00_0041;
    sh[SMPR_ADDR_FSSPD] = 22'h00_0027;
    sh[SMPR_ADDR_KNEE] = 22'h00_0408;
    for (int i = 9; i < 13; i++) sh[i] = 22'h00_0029;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 32; i++) rdchk(5'(i));
    $display("reset values done");
    for (int i = 0; i < 24; i++)
    begin
      a = 5'($unsigned($random(seed)) % 12) + 5'h02;
      if (a == SMPR_ADDR_SPEED) a = SMPR_ADDR_FSSPD;
      d = 22'($random(seed)) & 22'h3f_fffe; // Never the reserved rate code
      put(a, d);
      rdchk(a);
    end
    put(SMPR_ADDR_MARK, 22'h20_0000);
    rdchk(SMPR_ADDR_MARK);
    put(SMPR_ADDR_ELPOS, 22'h00_01ff);
    check("phase", {13'h0, phase}, 22'h00_01ff);
    put(SMPR_ADDR_MINSPD, 22'h00_1abc);
    @(negedge clk);
    check("lv", {9'h0, lv_opt, lv_thr}, 22'h00_1abc);
    check("knee", {8'h0, knee}, sh[SMPR_ADDR_KNEE]);
    check("hold", {14'h0, drv.amplitude}, sh[SMPR_ADDR_HOLD]);
    err(1'b0);
    $display("stopped access done");
    put(SMPR_ADDR_UP_RATE, 22'h00_0ffe);
    put(SMPR_ADDR_DN_RATE, 22'h00_0ffe);
    put(SMPR_ADDR_MAXSPD, 22'h00_0001);
    put(SMPR_ADDR_FSSPD, 22'h00_0400);
    move_req = 1'b1;
    wst(SMPR_ACCEL);
    check("up", {14'h0, drv.amplitude}, sh[SMPR_ADDR_UP]);
    wst(SMPR_CONST);
    check("run", {14'h0, drv.amplitude}, sh[SMPR_ADDR_RUN]);
    check("fs", {20'h0, drv.full_step, drv.boost}, 22'h3);
    sh[SMPR_ADDR_SPEED] = sh[SMPR_ADDR_MAXSPD] << 10;
    for (int i = 0; i < 5; i++)
    begin
      a = (i == 4) ? SMPR_ADDR_SPEED : (i == 3) ? SMPR_ADDR_KNEE : 5'(i + 3 + (i > 0));
      clr();
      host.wr(a == 5'h03 ? SMPR_ADDR_ELPOS : a, 22'($random(seed)));
      err(1'b1);
      rdchk(a == 5'h03 ? SMPR_ADDR_ELPOS : a);
    end
    clr();
    put(SMPR_ADDR_MINSPD, 22'h00_0123);
    err(1'b1);
    rdchk(SMPR_ADDR_MINSPD);
    move_req = 1'b0;
    wst(SMPR_DECEL);
    check("down", {14'h0, drv.amplitude}, sh[SMPR_ADDR_DOWN]);
    wst(SMPR_STOPPED);
    @(negedge clk);
    check("hold", {14'h0, drv.amplitude}, sh[SMPR_ADDR_HOLD]);
    sh[SMPR_ADDR_SPEED] = 22'h0;
    rdchk(SMPR_ADDR_SPEED);
    $display("motion done");
    results();
  end
endmodule // stepper_motion_parameter_regs_tb
`default_nettype wire
